// ---- shared/cctg_pkg.sv ----
// Constants for the card cycle timing generator.
// Assumes a 100 MHz system clock and a single AHB-Lite master.
package cctg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CNT_W         = 5;

  // Register byte offsets.
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Configuration and command field positions, and the configuration reset value.
  localparam int unsigned CFG_IO_BIT   = 0;
  localparam int unsigned CFG_WIDE_BIT = 1;
  localparam int unsigned CFG_WS_LSB   = 2;
  localparam int unsigned CFG_ZW_BIT   = 4;
  localparam int unsigned CMD_GO_BIT   = 0;
  localparam logic [4:0]  CFG_RESET    = 5'h00;

  // Interval lengths in clock periods, and the counter's one and zero.
  localparam logic [CNT_W-1:0] SU_IO      = 5'h03;
  localparam logic [CNT_W-1:0] SU_MEM_LO  = 5'h02;
  localparam logic [CNT_W-1:0] SU_MEM_HI  = 5'h04;
  localparam logic [CNT_W-1:0] HD_IO      = 5'h02;
  localparam logic [CNT_W-1:0] HD_MEM_LO  = 5'h02;
  localparam logic [CNT_W-1:0] HD_MEM_HI  = 5'h03;
  localparam logic [CNT_W-1:0] A8_PLAIN   = 5'h13;
  localparam logic [CNT_W-1:0] A8_WAIT    = 5'h17;
  localparam logic [CNT_W-1:0] A8_ZERO    = 5'h07;
  localparam logic [CNT_W-1:0] A16IO_LO   = 5'h07;
  localparam logic [CNT_W-1:0] A16IO_HI   = 5'h0b;
  localparam logic [CNT_W-1:0] A16M_WS0   = 5'h09;
  localparam logic [CNT_W-1:0] A16M_WS1   = 5'h0d;
  localparam logic [CNT_W-1:0] A16M_WS2   = 5'h11;
  localparam logic [CNT_W-1:0] A16M_WS3   = 5'h17;
  localparam logic [CNT_W-1:0] A16M_ZERO  = 5'h05;
  localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;

  typedef enum logic [3:0] {
    CCTG_IDLE   = 4'b0001,
    CCTG_SETUP  = 4'b0010,
    CCTG_ACTIVE = 4'b0100,
    CCTG_HOLD   = 4'b1000
  } cctg_phase_e;
endpackage

// ---- hw/cctg_top.sv ----
// Card cycle timing generator with an AHB-Lite register slave.
// Assumes one AHB-Lite master on the same clock; the card sits on the strobe outputs.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - All three intervals are counted in whole clock periods.
// - Setup and hold follow the window type and the upper wait bit, regardless of cycle size.
// - Setup: I/O 3 clocks; memory 2, or 4 with the upper wait bit.
// - 8-bit command: 19 plain, 23 with any wait bit, 7 zero-wait.
// - 16-bit I/O command: 7 clocks, or 11 with any wait bit.
// - 16-bit memory command: 9, 13, 17, 23 by code; 5 zero-wait.
// - Hold: I/O 2 clocks; memory 2, or 3 with the upper wait bit.
// - Zero-wait counts only when the wait-state value is zero.
module cctg_top
  import cctg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             card_addr_valid,
  output logic             card_cmd_n,
  output logic             cycle_busy,
  output logic             cycle_done
);

  // Module-local widths, taken from the package constants so they cannot drift apart.
  localparam int unsigned CFG_W = $bits(CFG_RESET);
  localparam int unsigned OFS_W = $bits(OFS_CFG);

  // The whole block is one registered record: reset and next-state logic touch every
  // field in one place, and every output below is a plain read of one of its fields.
  typedef struct packed {
    cctg_phase_e      phase;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] act_len;
    logic [CNT_W-1:0] hold_len;
    logic [4:0]       cfg;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rdata;
    logic             ready;
    logic             addr_valid;
    logic             cmd_n;
    logic             done;
    logic             resp;
  } cctg_state_s;

  cctg_state_s st;
  cctg_state_s next_st;

  // Status word: busy in bit 0 and the one-hot phase code just above it. Software can
  // poll it to see which interval a slow card cycle has reached.
  function automatic logic [31:0] status_word(input cctg_phase_e phase);
    status_word                        = 32'h0;
    status_word[0]                     = (phase != CCTG_IDLE);
    status_word[$bits(cctg_phase_e):1] = phase;
  endfunction

  // Setup and hold ignore the cycle size: only the window type and the upper wait bit matter.
  function automatic logic [CNT_W-1:0] setup_len(input logic io, input logic [1:0] ws);
    if (io) begin
      setup_len = SU_IO;
    end else begin
      setup_len = ws[1] ? SU_MEM_HI : SU_MEM_LO;
    end
  endfunction

  function automatic logic [CNT_W-1:0] hold_len_f(input logic io, input logic [1:0] ws);
    if (io) begin
      hold_len_f = HD_IO;
    end else begin
      hold_len_f = ws[1] ? HD_MEM_HI : HD_MEM_LO;
    end
  endfunction

  // A nonzero wait value always masks zero-wait, so the zero-wait test sits last.
  function automatic logic [CNT_W-1:0] active_len(input logic io, input logic wide,
                                                  input logic [1:0] ws, input logic zw);
    active_len = A8_PLAIN;
    if (!wide) begin
      if (ws != 2'h0) begin
        active_len = A8_WAIT;
      end else if (zw) begin
        active_len = A8_ZERO;
      end
    end else if (io) begin
      active_len = (ws != 2'h0) ? A16IO_HI : A16IO_LO;
    end else begin
      case (ws)
        2'h0:    active_len = zw ? A16M_ZERO : A16M_WS0;
        2'h1:    active_len = A16M_WS1;
        2'h2:    active_len = A16M_WS2;
        default: active_len = A16M_WS3;
      endcase
    end
  endfunction

  // Bus side: a transfer is taken when selected, NONSEQ or SEQ (htrans[1] set) and ready. The slave never
  // inserts wait states, so a write lands at the edge that ends its data phase and
  // read data is registered at the address edge, standing through the data phase.
  always_comb begin
    logic        take;
    logic        go;
    logic        cfg_io;
    logic        cfg_wide;
    logic [1:0]  cfg_ws;
    logic        cfg_zw;
    next_st       = st;
    take          = hsel && htrans[1] && hready;
    go            = 1'b0;
    cfg_io        = st.cfg[CFG_IO_BIT];
    cfg_wide      = st.cfg[CFG_WIDE_BIT];
    cfg_ws        = st.cfg[CFG_WS_LSB+:2];
    cfg_zw        = st.cfg[CFG_ZW_BIT];
    next_st.done  = 1'b0;
    next_st.ready = 1'b1;

    // Write data phase of the transfer taken one cycle earlier.
    // A start written while a cycle runs is dropped below, never queued.
    if (st.wr_pend) begin
      if (st.wr_addr == OFS_CFG) begin
        next_st.cfg = hwdata[CFG_W-1:0];
      end else if (st.wr_addr == OFS_CMD) begin
        go = hwdata[CMD_GO_BIT];
      end
    end
    next_st.wr_pend = take && hwrite;
    next_st.wr_addr = haddr[OFS_W-1:0];

    if (take && !hwrite) begin
      case (haddr[OFS_W-1:0])
        OFS_CFG:    next_st.rdata = 32'(st.cfg);
        OFS_STATUS: next_st.rdata = status_word(st.phase);
        default:    next_st.rdata = 32'h0;
      endcase
    end

    // Each interval loads its length minus one and counts down to zero, so a length of N
    // keeps the phase for exactly N clocks. The settings are copied at the start, which
    // lets software rewrite the window during a cycle without bending the running one.
    case (st.phase)
      CCTG_IDLE: begin
        // A start while a cycle runs is ignored; settings are sampled here only.
        if (go) begin
          next_st.phase    = CCTG_SETUP;
          next_st.cnt      = setup_len(cfg_io, cfg_ws) - CNT_ONE;
          next_st.act_len  = active_len(cfg_io, cfg_wide, cfg_ws,
                                        cfg_zw);
          next_st.hold_len = hold_len_f(cfg_io, cfg_ws);
        end
      end
      CCTG_SETUP: begin
        if (st.cnt == CNT_ZERO) begin
          next_st.phase = CCTG_ACTIVE;
          next_st.cnt   = st.act_len - CNT_ONE;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      CCTG_ACTIVE: begin
        if (st.cnt == CNT_ZERO) begin
          next_st.phase = CCTG_HOLD;
          next_st.cnt   = st.hold_len - CNT_ONE;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      CCTG_HOLD: begin
        // The done pulse marks the first idle clock, so it never overlaps the address
        // and a new start can be accepted on the very next write.
        if (st.cnt == CNT_ZERO) begin
          next_st.phase = CCTG_IDLE;
          next_st.done  = 1'b1;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      default: begin
        next_st.phase = CCTG_IDLE;
      end
    endcase

    // Strobes follow the next phase, so they change on the same edge as the phase
    // register and add no clock of lag to any interval.
    next_st.addr_valid = (next_st.phase != CCTG_IDLE);
    next_st.cmd_n      = (next_st.phase != CCTG_ACTIVE);

    // Synchronous reset wins over everything above. The command strobe idles high and
    // the bus answers ready from the first edge, so a master may start right after
    // reset is released.
    if (rst) begin
      next_st            = '0;
      next_st.phase      = CCTG_IDLE;
      next_st.cfg        = CFG_RESET;
      next_st.ready      = 1'b1;
      next_st.cmd_n      = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Outputs are register fields only. The response field stays OKAY because no access
  // to this slave can fail; unmapped offsets read as zero and ignore writes.
  assign hrdata          = st.rdata;
  assign hreadyout       = st.ready;
  assign hresp           = st.resp;
  assign card_addr_valid = st.addr_valid;
  assign card_cmd_n      = st.cmd_n;
  assign cycle_busy      = st.addr_valid;
  assign cycle_done      = st.done;
endmodule

// ---- testbench/cctg_card_model.sv ----
// Card side model: counts setup, active and hold clocks of each card cycle.
// Assumes the strobes are registered outputs of the generator on clk.
`timescale 1ns/1ps
module cctg_card_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       card_addr_valid,
  input  wire logic       card_cmd_n,
  output logic      [7:0] su_cnt,
  output logic      [7:0] act_cnt,
  output logic      [7:0] hd_cnt
);
  logic prev;
  // Whole clock periods are counted, as the card sees them at each edge.
  always_ff @(posedge clk) begin
    prev <= card_addr_valid;
    if (rst) begin
      su_cnt  <= 8'h00;
      act_cnt <= 8'h00;
      hd_cnt  <= 8'h00;
    end else if (card_addr_valid && !prev) begin
      su_cnt  <= 8'h01;
      act_cnt <= 8'h00;
      hd_cnt  <= 8'h00;
    end else if (card_addr_valid && card_cmd_n && act_cnt == 8'h00) begin
      su_cnt <= su_cnt + 8'h01;
    end else if (!card_cmd_n) begin
      act_cnt <= act_cnt + 8'h01;
    end else if (card_addr_valid) begin
      hd_cnt <= hd_cnt + 8'h01;
    end
  end
endmodule

// ---- testbench/cctg_props.sv ----
// Checker for the card strobes of the timing generator.
// Assumes only the top module's ports are visible; attached by bind.
`timescale 1ns/1ps
module cctg_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic card_addr_valid,
  input wire logic card_cmd_n,
  input wire logic cycle_busy,
  input wire logic cycle_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  cmd_in_cycle_a: assert property (!card_cmd_n |-> card_addr_valid)
    else $error("command low without address");
  busy_match_a: assert property (cycle_busy == card_addr_valid)
    else $error("busy differs from address valid");
  setup_min_a: assert property ($rose(card_addr_valid) |-> card_cmd_n [*2])
    else $error("setup too short");
  setup_max_a: assert property ($rose(card_addr_valid) |-> ##[2:4] !card_cmd_n)
    else $error("setup too long");
  active_len_a: assert property ($fell(card_cmd_n) |-> !card_cmd_n [*5] ##[1:19] card_cmd_n)
    else $error("active interval out of range");
  hold_len_a: assert property ($rose(card_cmd_n) |-> card_addr_valid [*2] ##[1:2] !card_addr_valid)
    else $error("hold interval out of range");
  done_pulse_a: assert property ($fell(card_addr_valid) |-> cycle_done ##1 !cycle_done)
    else $error("done pulse wrong");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or error response");
endmodule
bind cctg_top cctg_props u_props (.clk(clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .card_addr_valid(card_addr_valid), .card_cmd_n(card_cmd_n), .cycle_busy(cycle_busy),
  .cycle_done(cycle_done));

// ---- testbench/tb.sv ----
// Testbench: runs every window setting through a card cycle and checks each interval.
// Assumes a zero-wait AHB-Lite slave whose hreadyout feeds back as hready.
`timescale 1ns/1ps
module tb;
  import cctg_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic card_addr_valid, card_cmd_n, cycle_busy, cycle_done;
  logic [7:0] su_cnt, act_cnt, hd_cnt, es, ea, eh;
  logic [4:0] cfg;
  int mismatches = 0, tests_run = 0, c, n;
  initial forever #5 clk = ~clk;
  cctg_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .card_addr_valid(card_addr_valid),
    .card_cmd_n(card_cmd_n), .cycle_busy(cycle_busy), .cycle_done(cycle_done));
  cctg_card_model card (.clk(clk), .rst(rst), .card_addr_valid(card_addr_valid),
    .card_cmd_n(card_cmd_n), .su_cnt(su_cnt), .act_cnt(act_cnt), .hd_cnt(hd_cnt));
  task automatic report_and_stop;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: bus ready timeout", $time);
      report_and_stop();
    end
  endtask
  // The address phase is held until ready is seen, then the data phase follows.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0; hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    ahb(1'b0, 32'h0000000c, 32'h0); chk(r, 32'h0);
    ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0); chk(r, {27'h0, CCTG_IDLE, 1'b0});
    for (c = 0; c < 32; c++) begin
      cfg = c[4:0];
      es = cfg[0] ? 8'h03 : (cfg[3] ? 8'h04 : 8'h02);
      eh = (!cfg[0] && cfg[3]) ? 8'h03 : 8'h02;
      if (cfg[3:2] != 2'h0) ea = !cfg[1] ? 8'h17 : cfg[0] ? 8'h0b :
        cfg[3:2] == 2'h1 ? 8'h0d : cfg[3:2] == 2'h2 ? 8'h11 : 8'h17;
      else ea = !cfg[1] ? (cfg[4] ? 8'h07 : 8'h13) : cfg[0] ? 8'h07 : (cfg[4] ? 8'h05 : 8'h09);
      ahb(1'b1, {24'h0, OFS_CFG}, {27'h0, cfg});
      ahb(1'b0, {24'h0, OFS_CFG}, 32'h0); chk(r, {27'h0, cfg});
      ahb(1'b1, {24'h0, OFS_CMD}, 32'h1);
      // A second start while busy must not queue another cycle.
      ahb(1'b1, {24'h0, OFS_CMD}, 32'h1);
      ahb(1'b1, {24'h0, OFS_CFG}, {27'h0, ~cfg});
      // Four clocks into the cycle every setting is past setup and still in the command.
      ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0); chk(r, {27'h0, CCTG_ACTIVE, 1'b1});
      n = 0;
      while (cycle_done !== 1'b1 && n < 200) begin @(posedge clk); n++; end
      if (cycle_done !== 1'b1) begin
        mismatches++;
        $display("wrong value at %0t: card cycle timeout", $time);
        report_and_stop();
      end
      chk({24'h0, su_cnt}, {24'h0, es});
      chk({24'h0, act_cnt}, {24'h0, ea});
      chk({24'h0, hd_cnt}, {24'h0, eh});
      repeat (2) @(posedge clk);
      chk({31'h0, cycle_busy}, 32'h0);
    end
    report_and_stop();
  end
endmodule
